// ---- hw/lcdcfg_clk_sel.sv ----
// Pixel and memory clock divider selection, as tick pulses on sys_clk
`timescale 1ns/100ps
module lcdcfg_clk_sel (
    input  wire logic             sys_clk,     // System clock, the input clock
    input  wire logic             sys_rst,     // Synchronous reset, high
    input  wire logic             rot_en,      // Rotated refresh enabled
    input  wire logic             rot_alt,     // Alternate rotated mode
    input  wire logic [1:0]       clk_sel,     // Pixel clock select code
    input  wire logic             base_half,   // Base clock is half input
    input  wire logic             mclk_half,   // Landscape memory clock halved
    output logic                  pixel_tick,  // One pulse per pixel clock
    output logic                  mem_tick     // One pulse per memory clock
);
    import lcdcfg_pkg::*;

    lcdcfg_mode_e mode;
    logic [1:0]   pix_log2;
    logic [1:0]   mem_log2;
    logic         base_q;
    logic         base_tick;
    logic [2:0]   cnt_q;

    // Divide ratio minus one as a mask on the base tick counter
    function automatic logic [2:0] div_mask(input logic [1:0] log2);
        case (log2)
            2'h0:    div_mask = 3'h0;
            2'h1:    div_mask = 3'h1;
            2'h2:    div_mask = 3'h3;
            default: div_mask = 3'h7;
        endcase
    endfunction : div_mask

    // Mode decode and divider choice
    always_comb
    begin
        mode = rot_en ? (rot_alt ? MODE_ALT : MODE_DFLT) : MODE_LAND;
        case (mode)
            MODE_LAND:
            begin
                pix_log2 = 2'h0;
                mem_log2 = {1'b0, mclk_half};
            end
            MODE_DFLT:
            begin
                pix_log2 = clk_sel;
                mem_log2 = clk_sel;
            end
            MODE_ALT:
            begin
                pix_log2 = (clk_sel == 2'h0) ? 2'h1 : clk_sel;
                mem_log2 = (clk_sel == 2'h0) ? 2'h0 : clk_sel - 2'h1;
            end
            default:
            begin
                pix_log2 = 2'h0;
                mem_log2 = 2'h0;
            end
        endcase
    end

    // Base clock: every edge, or every second edge when halved
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            base_q <= 1'b0;
        else
            base_q <= base_half ? ~base_q : 1'b1;
    end
    assign base_tick = base_half ? base_q : 1'b1;

    // Base tick counter shared by both dividers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cnt_q <= 3'h0;
        else if (base_tick)
            cnt_q <= cnt_q + 3'h1;
    end

    // Registered tick outputs
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pixel_tick <= 1'b0;
            mem_tick   <= 1'b0;
        end
        else
        begin
            pixel_tick <= base_tick && ((cnt_q & div_mask(pix_log2)) == div_mask(pix_log2));
            mem_tick   <= base_tick && ((cnt_q & div_mask(mem_log2)) == div_mask(mem_log2));
        end
    end

endmodule : lcdcfg_clk_sel

// ---- hw/lcdcfg_frame_calc.sv ----
// Frame timing arithmetic from the panel size fields
`timescale 1ns/100ps
module lcdcfg_frame_calc (
    input  wire logic        sys_clk,      // System clock
    input  wire logic        sys_rst,      // Synchronous reset, high
    input  wire logic [6:0]  hwidth,       // Horizontal width field
    input  wire logic [4:0]  hblank,       // Horizontal blanking field
    input  wire logic [9:0]  vsize,        // Vertical size field
    input  wire logic [5:0]  vblank,       // Vertical blanking field
    input  wire logic        dual,         // Dual passive panel
    output logic [9:0]       hdisp,        // Display pixels per line
    output logic [8:0]       hblank_pix,   // Blank pixels per line
    output logic [10:0]      vdisp,        // Display lines
    output logic [5:0]       vblank_ln,    // Blank lines
    output logic [22:0]      frame_len     // Pixel clocks per frame
);
    import lcdcfg_pkg::*;

    logic [9:0]  hd;
    logic [8:0]  hb;
    logic [10:0] vd;
    logic [10:0] htot;
    logic [10:0] vtot;

    // Periods and totals
    always_comb
    begin
        hd   = ({3'h0, hwidth} + 10'h001) * H_PIX_PER_UNIT;
        hb   = 9'(({4'h0, hblank} + 9'(H_BLANK_BIAS)) * 9'h008);
        vd   = {1'b0, vsize} + 11'h001;
        htot = {1'b0, hd} + {2'h0, hb};
        vtot = dual ? ({1'b0, vd[10:1]} + {5'h00, vblank})
                    : (vd + {5'h00, vblank});
    end

    // Registered results
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            hdisp      <= 10'h000;
            hblank_pix <= 9'h000;
            vdisp      <= 11'h000;
            vblank_ln  <= 6'h00;
            frame_len  <= 23'h000000;
        end
        else
        begin
            hdisp      <= hd;
            hblank_pix <= hb;
            vdisp      <= vd;
            vblank_ln  <= vblank;
            frame_len  <= {1'b0, 22'({11'h000, htot} * {11'h000, vtot})} << dual;
        end
    end

endmodule : lcdcfg_frame_calc

// ---- hw/lcdcfg_pkg.sv ----
// Shared constants and types for the LCD controller configuration slice
package lcdcfg_pkg;

    // Register port widths
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned GPIO_N = 5;

    // Register offsets
    localparam logic [4:0] OFS_SYS_CFG      = 5'h02;
    localparam logic [4:0] OFS_HORIZ_WIDTH  = 5'h04;
    localparam logic [4:0] OFS_VERT_LO      = 5'h05;
    localparam logic [4:0] OFS_VERT_HI      = 5'h06;
    localparam logic [4:0] OFS_HORIZ_BLANK  = 5'h08;
    localparam logic [4:0] OFS_VERT_BLANK   = 5'h0A;
    localparam logic [4:0] OFS_PIN_DIR      = 5'h18;
    localparam logic [4:0] OFS_PIN_LEVEL    = 5'h19;
    localparam logic [4:0] OFS_SCRATCH      = 5'h1A;
    localparam logic [4:0] OFS_ROTATION     = 5'h1B;
    localparam logic [4:0] OFS_STRIDE       = 5'h1C;
    localparam logic [4:0] OFS_PANEL_MODE   = 5'h1D;
    localparam logic [4:0] OFS_TEST_A       = 5'h1E;
    localparam logic [4:0] OFS_TEST_B       = 5'h1F;

    // Field positions
    localparam int unsigned ROT_EN_BIT       = 7;
    localparam int unsigned ROT_ALT_BIT      = 6;
    localparam int unsigned CFG_HALF_BIT     = 4;
    localparam int unsigned CFG_MCLK_BIT     = 5;
    localparam int unsigned PANEL_DUAL_BIT   = 0;
    localparam int unsigned PANEL_ACTIVE_BIT = 1;

    // Writable bits of the rotation, clock configuration and GPIO registers; pins taken by an active panel
    localparam logic [7:0] ROT_WR_MASK   = 8'hC3;
    localparam logic [7:0] CFG_WR_MASK   = 8'h30;
    localparam logic [4:0] GPIO_WR_MASK  = 5'h1F;
    localparam logic [4:0] DEDICATED_PIN = 5'h0F;

    // Values after reset
    localparam logic [7:0] RST_BYTE      = 8'h00;
    localparam logic [4:0] RST_PINS      = 5'h00;

    // Stride and timing arithmetic
    localparam logic [8:0] STRIDE_ZERO_BYTES = 9'h100;
    localparam logic [9:0] H_PIX_PER_UNIT    = 10'h008;
    localparam logic [5:0] H_BLANK_BIAS      = 6'h04;

    // Refresh orientation, one-hot
    typedef enum logic [2:0] {
        MODE_LAND = 3'b001,
        MODE_DFLT = 3'b010,
        MODE_ALT  = 3'b100
    } lcdcfg_mode_e;

endpackage : lcdcfg_pkg

// ---- hw/lcdcfg_regs.sv ----
// Configuration register bank: GPIO, scratch, rotation, stride, timing
//
// Added by the designer: the plain strobed port.
`timescale 1ns/100ps
module lcdcfg_regs (
    input  wire logic                          sys_clk,             // System clock
    input  wire logic                          sys_rst,             // Synchronous reset, high
    input  wire logic [lcdcfg_pkg::ADDR_W-1:0] reg_addr,            // Register index
    input  wire logic [lcdcfg_pkg::DATA_W-1:0] reg_wr_data,         // Write data
    input  wire logic                          reg_wr_en,           // Write strobe
    input  wire logic                          reg_rd_en,           // Read strobe
    output logic [lcdcfg_pkg::DATA_W-1:0]      reg_rd_data,         // Read data, next cycle
    input  wire logic [lcdcfg_pkg::GPIO_N-1:0] gpio_in,             // GPIO pin levels
    output logic [lcdcfg_pkg::GPIO_N-1:0]      gpio_out,            // GPIO drive levels
    output logic [lcdcfg_pkg::GPIO_N-1:0]      gpio_oe,             // GPIO drive enables
    output logic                               rotate_en,           // Rotated refresh on
    output logic                               rotate_alt,          // Alternate rotated mode
    output logic                               panel_dual,          // Dual passive panel
    output logic                               panel_active,        // Active-matrix panel
    output logic                               pixel_tick,          // Pixel clock pulse
    output logic                               mem_tick,            // Memory clock pulse
    output logic [8:0]                         line_stride_bytes,   // Rotated line stride
    output logic [9:0]                         horiz_display_period, // Display pixels
    output logic [8:0]                         horiz_blank_period,  // Blank pixels
    output logic [10:0]                        vert_display_period, // Display lines
    output logic [5:0]                         vert_blank_period,   // Blank lines
    output logic [22:0]                        frame_cycles         // Pixel clocks per frame
);
    import lcdcfg_pkg::*;

    logic [GPIO_N-1:0] pin_dir_q;
    logic [GPIO_N-1:0] pin_level_q;
    logic [7:0]        scratch_q;
    logic [7:0]        rotation_q;
    logic [7:0]        stride_q;
    logic [7:0]        sys_cfg_q;
    logic [7:0]        panel_mode_q;
    logic [6:0]        hwidth_q;
    logic [4:0]        hblank_q;
    logic [9:0]        vsize_q;
    logic [5:0]        vblank_q;
    logic [GPIO_N-1:0] pin_meta_q;
    logic [GPIO_N-1:0] pin_sync_q;
    logic [GPIO_N-1:0] dir_eff;
    logic [7:0]        rd_d;

    // Write decode helper
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // Direction only counts on pins not taken by the panel
    assign dir_eff = pin_dir_q & ~(panel_mode_q[PANEL_ACTIVE_BIT] ? DEDICATED_PIN : RST_PINS);

    // Two-stage synchroniser on the pin inputs
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_meta_q <= RST_PINS;
            pin_sync_q <= RST_PINS;
        end
        else
        begin
            pin_meta_q <= gpio_in;
            pin_sync_q <= pin_meta_q;
        end
    end

    // GPIO direction and output latch
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            pin_dir_q   <= RST_PINS;
            pin_level_q <= RST_PINS;
        end
        else if (reg_wr_en)
        begin
            if (hit(reg_addr, OFS_PIN_DIR))
                pin_dir_q <= reg_wr_data[GPIO_N-1:0] & GPIO_WR_MASK;
            if (hit(reg_addr, OFS_PIN_LEVEL))
                pin_level_q <= reg_wr_data[GPIO_N-1:0] & GPIO_WR_MASK;
        end
    end

    // GPIO pin drive
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            gpio_out <= RST_PINS;
            gpio_oe  <= RST_PINS;
        end
        else
        begin
            gpio_out <= pin_level_q;
            gpio_oe  <= dir_eff;
        end
    end

    // Scratch, rotation and stride registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            scratch_q  <= RST_BYTE;
            rotation_q <= RST_BYTE;
            stride_q   <= RST_BYTE;
        end
        else if (reg_wr_en)
        begin
            if (hit(reg_addr, OFS_SCRATCH))
                scratch_q <= reg_wr_data;
            if (hit(reg_addr, OFS_ROTATION))
                rotation_q <= reg_wr_data & ROT_WR_MASK;
            if (hit(reg_addr, OFS_STRIDE))
                stride_q <= reg_wr_data;
        end
    end

    // Clock configuration and panel mode registers
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            sys_cfg_q    <= RST_BYTE;
            panel_mode_q <= RST_BYTE;
        end
        else if (reg_wr_en)
        begin
            if (hit(reg_addr, OFS_SYS_CFG))
                sys_cfg_q <= reg_wr_data & CFG_WR_MASK;
            if (hit(reg_addr, OFS_PANEL_MODE))
                panel_mode_q <= {6'h00, reg_wr_data[1:0]};
        end
    end

    // Panel size fields
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            hwidth_q <= 7'h00;
            hblank_q <= 5'h00;
            vsize_q  <= 10'h000;
            vblank_q <= 6'h00;
        end
        else if (reg_wr_en)
        begin
            if (hit(reg_addr, OFS_HORIZ_WIDTH))
                hwidth_q <= reg_wr_data[6:0];
            if (hit(reg_addr, OFS_HORIZ_BLANK))
                hblank_q <= reg_wr_data[4:0];
            if (hit(reg_addr, OFS_VERT_LO))
                vsize_q[7:0] <= reg_wr_data;
            if (hit(reg_addr, OFS_VERT_HI))
                vsize_q[9:8] <= reg_wr_data[1:0];
            if (hit(reg_addr, OFS_VERT_BLANK))
                vblank_q <= reg_wr_data[5:0];
        end
    end

    // Read multiplexer; test registers and unmapped indexes read zero
    always_comb
    begin
        case (reg_addr)
            OFS_SYS_CFG:     rd_d = sys_cfg_q;
            OFS_HORIZ_WIDTH: rd_d = {1'b0, hwidth_q};
            OFS_VERT_LO:     rd_d = vsize_q[7:0];
            OFS_VERT_HI:     rd_d = {6'h00, vsize_q[9:8]};
            OFS_HORIZ_BLANK: rd_d = {3'h0, hblank_q};
            OFS_VERT_BLANK:  rd_d = {2'h0, vblank_q};
            OFS_PIN_DIR:     rd_d = {3'h0, pin_dir_q};
            OFS_PIN_LEVEL:   rd_d = {3'h0, (pin_sync_q & ~dir_eff) | (pin_level_q & dir_eff)};
            OFS_SCRATCH:     rd_d = scratch_q;
            OFS_ROTATION:    rd_d = rotation_q;
            OFS_STRIDE:      rd_d = stride_q;
            OFS_PANEL_MODE:  rd_d = panel_mode_q;
            OFS_TEST_A:      rd_d = RST_BYTE;
            OFS_TEST_B:      rd_d = RST_BYTE;
            default:         rd_d = RST_BYTE;
        endcase
    end

    // Read data register, loaded by the read strobe only
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            reg_rd_data <= RST_BYTE;
        else if (reg_rd_en)
            reg_rd_data <= rd_d;
    end

    // Mode, panel and stride outputs
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rotate_en         <= 1'b0;
            rotate_alt        <= 1'b0;
            panel_dual        <= 1'b0;
            panel_active      <= 1'b0;
            line_stride_bytes <= STRIDE_ZERO_BYTES;
        end
        else
        begin
            rotate_en         <= rotation_q[ROT_EN_BIT];
            rotate_alt        <= rotation_q[ROT_EN_BIT] & rotation_q[ROT_ALT_BIT];
            panel_dual        <= panel_mode_q[PANEL_DUAL_BIT];
            panel_active      <= panel_mode_q[PANEL_ACTIVE_BIT];
            line_stride_bytes <= (stride_q == 8'h00) ? STRIDE_ZERO_BYTES
                                                     : {1'b0, stride_q};
        end
    end

    // Clock divider selection
    lcdcfg_clk_sel u_clk_sel (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .rot_en     (rotation_q[ROT_EN_BIT]),
        .rot_alt    (rotation_q[ROT_ALT_BIT]),
        .clk_sel    (rotation_q[1:0]),
        .base_half  (sys_cfg_q[CFG_HALF_BIT]),
        .mclk_half  (sys_cfg_q[CFG_MCLK_BIT]),
        .pixel_tick (pixel_tick),
        .mem_tick   (mem_tick)
    );

    // Frame timing arithmetic
    lcdcfg_frame_calc u_frame_calc (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .hwidth     (hwidth_q),
        .hblank     (hblank_q),
        .vsize      (vsize_q),
        .vblank     (vblank_q),
        .dual       (panel_mode_q[PANEL_DUAL_BIT]),
        .hdisp      (horiz_display_period),
        .hblank_pix (horiz_blank_period),
        .vdisp      (vert_display_period),
        .vblank_ln  (vert_blank_period),
        .frame_len  (frame_cycles)
    );

    // Input pins read their synchronised level
    chk_input_read: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd_en && reg_addr == OFS_PIN_LEVEL)
        |=> ((reg_rd_data[GPIO_N-1:0] & ~$past(dir_eff))
             == ($past(pin_sync_q) & ~$past(dir_eff))))
        else $error("input pin status mismatch");

    // A status write reaches the pin two edges later
    chk_output_level: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr_en && reg_addr == OFS_PIN_LEVEL)
        |-> ##2 (gpio_out == $past(reg_wr_data[GPIO_N-1:0], 2)))
        else $error("output level not driven");

    // Output direction enables the drive
    chk_output_enable: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr_en && reg_addr == OFS_PIN_DIR && reg_wr_data[4] && !$past(sys_rst))
        |-> ##2 gpio_oe[4])
        else $error("output pin not enabled");

    // Dedicated panel pins are never driven here while the active panel mode is set
    chk_dedicated_off: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        $past(panel_mode_q[PANEL_ACTIVE_BIT]) |-> ((gpio_oe & DEDICATED_PIN) == RST_PINS))
        else $error("dedicated pin driven");

    // Scratch reads back what was written
    chk_scratch_hold: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr_en && reg_addr == OFS_SCRATCH) ##1 (reg_rd_en && reg_addr == OFS_SCRATCH)
        |=> (reg_rd_data == $past(reg_wr_data, 2)))
        else $error("scratch readback wrong");

    // Reserved rotation bits read zero
    chk_rotation_rsvd: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd_en && reg_addr == OFS_ROTATION) |=> (reg_rd_data[5:2] == 4'h0))
        else $error("reserved rotation bits set");

    // Stride zero stands for 256 bytes
    chk_stride_zero: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (stride_q == 8'h00) |=> (line_stride_bytes == 9'h100))
        else $error("zero stride not 256");

    // Nonzero stride passes unchanged
    chk_stride_pass: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (stride_q != 8'h00) |=> (line_stride_bytes == {1'b0, $past(stride_q)}))
        else $error("stride value altered");

    // Factory test registers read zero
    chk_test_quiet: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd_en && (reg_addr == OFS_TEST_A || reg_addr == OFS_TEST_B))
        |=> (reg_rd_data == 8'h00))
        else $error("test register not zero");

    // Upper GPIO bits read zero
    chk_gpio_upper: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_rd_en && (reg_addr == OFS_PIN_DIR || reg_addr == OFS_PIN_LEVEL))
        |=> (reg_rd_data[7:5] == 3'h0))
        else $error("upper gpio bits set");

    // Landscape pixel clock runs at base rate
    chk_land_pixel: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (!rotation_q[ROT_EN_BIT] && !sys_cfg_q[CFG_HALF_BIT]) [*3] |-> pixel_tick)
        else $error("landscape pixel tick missing");

    // A rotation write reaches the enable output two edges later
    chk_rotate_follow: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr_en && reg_addr == OFS_ROTATION)
        |-> ##2 (rotate_en == $past(reg_wr_data[ROT_EN_BIT], 2)))
        else $error("rotation enable not applied");

    // Alternate mode shows only while rotation is on
    chk_alt_follow: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr_en && reg_addr == OFS_ROTATION)
        |-> ##2 (rotate_alt == ($past(reg_wr_data[ROT_EN_BIT], 2)
                               && $past(reg_wr_data[ROT_ALT_BIT], 2))))
        else $error("alternate mode not applied");

    // A nonzero stride write reaches the stride output two edges later
    chk_stride_write: assert property (
        @(posedge sys_clk) disable iff (sys_rst)
        (reg_wr_en && reg_addr == OFS_STRIDE && reg_wr_data != 8'h00)
        |-> ##2 (line_stride_bytes == {1'b0, $past(reg_wr_data, 2)}))
        else $error("stride write not applied");

endmodule : lcdcfg_regs

// ---- sim/lcdcfg_regs_bench.sv ----
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
module lcdcfg_regs_bench;
    import lcdcfg_pkg::*;
    logic        sys_clk     = 1'b0;
    logic        sys_rst     = 1'b1;
    logic [4:0]  reg_addr    = 5'h00;
    logic [7:0]  reg_wr_data = 8'h00;
    logic        reg_wr_en   = 1'b0;
    logic        reg_rd_en   = 1'b0;
    logic [4:0]  gpio_in     = 5'h00;
    logic [7:0]  reg_rd_data;
    logic [4:0]  gpio_out, gpio_oe;
    logic        rotate_en, rotate_alt, panel_dual, panel_active, pixel_tick, mem_tick;
    logic [8:0]  line_stride_bytes, horiz_blank_period;
    logic [9:0]  horiz_display_period;
    logic [10:0] vert_display_period;
    logic [5:0]  vert_blank_period;
    logic [22:0] frame_cycles;
    int          n_fail    = 0;
    int          tests_run = 0;
    int          n_pix, n_mem, htot;
    // Clock select table: config, rotation, expected pixel and memory ticks in 64 cycles
    logic [7:0]  cfg_t [6] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h00, 8'h10};
    logic [7:0]  rot_t [6] = '{8'h00, 8'h03, 8'h82, 8'hC0, 8'hC3, 8'h81};
    int          pix_t [6] = '{64, 64, 16, 32, 8, 16};
    int          mem_t [6] = '{64, 32, 16, 64, 16, 16};

    lcdcfg_regs uut (.sys_clk, .sys_rst, .reg_addr, .reg_wr_data, .reg_wr_en, .reg_rd_en,
        .reg_rd_data, .gpio_in, .gpio_out, .gpio_oe, .rotate_en, .rotate_alt, .panel_dual,
        .panel_active, .pixel_tick, .mem_tick, .line_stride_bytes, .horiz_display_period,
        .horiz_blank_period, .vert_display_period, .vert_blank_period, .frame_cycles);

    // Free-running 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // Compare and count
    task automatic chk(input logic [22:0] got, input logic [22:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en   <= 1'b0;
    endtask : wr

    // One-cycle read strobe, data sampled in the following cycle
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_rd_en <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        #1;
        chk(reg_rd_data, exp);
    endtask : rd_chk

    // Write then read back with no gap between the two strobes
    task automatic wr_rd_chk(input logic [4:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr    <= a;
        reg_wr_data <= d;
        reg_wr_en   <= 1'b1;
        @(posedge sys_clk);
        reg_wr_en   <= 1'b0;
        reg_rd_en   <= 1'b1;
        @(posedge sys_clk);
        reg_rd_en   <= 1'b0;
        #1;
        chk(reg_rd_data, exp);
    endtask : wr_rd_chk

    // Let registered outputs and synchronisers settle
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle

    // Count tick pulses over a window after the divider has settled
    task automatic count_ticks;
        n_pix = 0;
        n_mem = 0;
        settle(16);
        repeat (64)
        begin
            @(posedge sys_clk);
            #1;
            n_pix += int'(pixel_tick);
            n_mem += int'(mem_tick);
        end
    endtask : count_ticks

    // Print counts and verdict, then stop
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // Hang guard, far beyond the roughly 600 cycles the tests need
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        $display("mismatch at %0t: watchdog expired", $time);
        give_verdict();
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        wr_rd_chk(OFS_SCRATCH, 8'h55, 8'h55);
        wr(OFS_SCRATCH, 8'hAA);
        rd_chk(OFS_SCRATCH, 8'hAA);
        wr(OFS_ROTATION, 8'hFB);
        rd_chk(OFS_ROTATION, 8'hC3);
        chk({rotate_en, rotate_alt}, 2'b11);
        wr(OFS_ROTATION, 8'h40);
        settle(2);
        chk({rotate_en, rotate_alt}, 2'b00);
        for (int i = 0; i < 3; i++)
        begin
            wr(OFS_STRIDE, 8'(i * 127));
            settle(2);
            chk(line_stride_bytes, (i == 0) ? 9'h100 : 9'(i * 127));
        end
        rd_chk(OFS_TEST_A, 8'h00);
        $display("registers test done");
        wr(OFS_PIN_DIR, 8'hFF);
        rd_chk(OFS_PIN_DIR, 8'h1F);
        wr(OFS_PIN_LEVEL, 8'hEA);
        settle(3);
        chk({gpio_out, gpio_oe}, {5'h0A, 5'h1F});
        wr(OFS_PANEL_MODE, 8'h02);
        gpio_in <= 5'h15;
        settle(4);
        chk(gpio_oe, 5'h10);
        chk({panel_dual, panel_active}, 2'b01);
        rd_chk(OFS_PIN_LEVEL, 8'h05);
        wr(OFS_PANEL_MODE, 8'h00);
        wr(OFS_PIN_DIR, 8'h00);
        settle(4);
        chk(gpio_oe, 5'h00);
        rd_chk(OFS_PIN_LEVEL, 8'h15);
        $display("pin test done");
        wr(OFS_HORIZ_WIDTH, 8'h7E);
        wr(OFS_HORIZ_BLANK, 8'h1F);
        wr(OFS_VERT_LO, 8'h03);
        wr(OFS_VERT_HI, 8'h03);
        wr(OFS_VERT_BLANK, 8'h3F);
        settle(4);
        htot = (8'h7E + 1) * 8 + (8'h1F + 4) * 8;
        chk({horiz_display_period, horiz_blank_period}, {10'd1016, 9'd280});
        chk({vert_display_period, vert_blank_period}, {11'd772, 6'd63});
        chk(frame_cycles, 23'(htot * (772 + 63)));
        wr(OFS_PANEL_MODE, 8'h01);
        settle(4);
        chk({panel_dual, panel_active}, 2'b10);
        chk(frame_cycles, 23'(2 * htot * (772 / 2 + 63)));
        $display("frame test done");
        for (int i = 0; i < 6; i++)
        begin
            wr(OFS_SYS_CFG, cfg_t[i]);
            wr(OFS_ROTATION, rot_t[i]);
            count_ticks();
            chk(23'(n_pix), 23'(pix_t[i]));
            chk(23'(n_mem), 23'(mem_t[i]));
        end
        $display("clock select test done");
        give_verdict();
    end
endmodule : lcdcfg_regs_bench
